/* rtl/psr_consts.vh */
// constants for the processor flags register block
// assumes inclusion by bare name from the design files
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH
`define PSR_ADDR_BANK0    9'h003
`define PSR_ADDR_MASK     9'h07f
`define PSR_BIT_IND_BANK_POS  7
`define PSR_BIT_RPH_POS       6
`define PSR_BIT_RPL_POS       5
`define PSR_BIT_TIMEOUT_POS   4
`define PSR_BIT_PWRDN_POS     3
`define PSR_BIT_Z_POS         2
`define PSR_BIT_NIB_CARRY_POS 1
`define PSR_BIT_C_POS         0
`define PSR_RESET_UPPER   3'h0
`define PSR_RESET_TIMEOUT 1'b1
`define PSR_RESET_PWRDN   1'b1
`define PSR_RESET_ALU     3'h0
`define PSR_NIB_MSB       3
`define PSR_ALU_OP_ADD    2'h0
`define PSR_ALU_OP_SUB    2'h1
`define PSR_ALU_OP_LOGIC  2'h2
`define PSR_ALU_OP_CLEAR  2'h3
`endif

/* rtl/psr_alu_flags.v */
// flag generator: computes result and zero, nibble carry, carry
// assumes operands valid in the same cycle as the op code
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_alu_flags #(
  parameter WIDTH = 8
) (
  input  wire [1:0]       op,
  input  wire [WIDTH-1:0] file_operand,
  input  wire [WIDTH-1:0] w_operand,
  input  wire [WIDTH-1:0] logic_result,
  output reg  [WIDTH-1:0] result,
  output wire             zero_out,
  output reg              nibble_carry_out,
  output reg              carry_out
);
  // ***************************
  // add / subtract with carries
  // ***************************
  reg [WIDTH:0] full_sum;
  reg [4:0]     nib_sum;
  reg [WIDTH-1:0] addend;
  always @* begin
    addend           = w_operand;
    result           = logic_result;
    nibble_carry_out = 1'b0;
    carry_out        = 1'b0;
    full_sum         = {(WIDTH+1){1'b0}};
    nib_sum          = 5'h00;
    case (op)
      `PSR_ALU_OP_ADD, `PSR_ALU_OP_SUB: begin
        // subtraction adds two's complement of w
        if (op == `PSR_ALU_OP_SUB) begin
          addend = ~w_operand; // R8
        end
        full_sum = {1'b0, file_operand} + {1'b0, addend} + {{WIDTH{1'b0}}, (op == `PSR_ALU_OP_SUB)};
        nib_sum  = {1'b0, file_operand[`PSR_NIB_MSB:0]} + {1'b0, addend[`PSR_NIB_MSB:0]}
                   + {4'h0, (op == `PSR_ALU_OP_SUB)};
        result           = full_sum[WIDTH-1:0];
        nibble_carry_out = nib_sum[4]; // R10 R8
        carry_out        = full_sum[WIDTH]; // R10 R8
      end
      `PSR_ALU_OP_CLEAR: begin
        result = {WIDTH{1'b0}};
      end
      default: begin
        result = logic_result;
      end
    endcase
  end
  assign zero_out = (result == {WIDTH{1'b0}}); // R10
endmodule

/* rtl/psr_flags_reg.v */
// processor flags register: alu flags, reset cause and bank select
// assumes datapath presents one instruction per enabled cycle
// assumes reset-cause pulses come from the reset and sleep logic
// How it works
// R1: the register answers at its address in all four banks.
// R2: it holds alu flags, reset-cause bits and bank-select bits.
// R3: any instruction may write it like an ordinary file register.
// R4: when the instruction sets flags, flag results override written flag bits.
// R5: timeout and power-down bits ignore writes; only reset and sleep logic moves them.
// R6: a clear-file on it zeroes bank bits, keeps reset and carry bits, sets zero.
// R7: software should alter it only with bit clear, bit set, swap and move-to-file.
// R8: in subtraction carry and nibble carry are inverted borrows via two's complement.
// R9: bit 7 selects indirect bank pair, bits 6-5 select the direct bank.
// R10: zero on zero result, carries out of bit 3 and msb; timeout/sleep clear flags.
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_flags_reg #(
  parameter WIDTH = 8
) (
  input  wire             core_clk,
  input  wire             reset,
  input  wire             instr_en,
  input  wire [8:0]       dest_addr,
  input  wire             dest_write,
  input  wire [1:0]       alu_op,
  input  wire             flags_affect_z,
  input  wire             flags_affect_c,
  input  wire [WIDTH-1:0] file_operand,
  input  wire [WIDTH-1:0] w_operand,
  input  wire [WIDTH-1:0] logic_result,
  input  wire             power_up_event,
  input  wire             clrwdt_event,
  input  wire             watchdog_expired,
  input  wire             sleep_entry,
  output reg  [WIDTH-1:0] flags_read_data,
  output wire [WIDTH-1:0] alu_result,
  output wire             indirect_bank_select,
  output wire [1:0]       direct_bank,
  output wire             dest_is_flags
);
  // ***************************
  // storage
  // ***************************
  // bank select
  reg indirect_bank_reg;
  reg direct_bank_select_hi;
  reg direct_bank_select_lo;
  // reset cause
  reg watchdog_timeout_flag;
  reg power_down_flag;
  // alu flags
  reg zero_flag;
  reg nibble_carry_flag;
  reg carry_flag;
  wire alu_zero;
  wire alu_nib;
  wire alu_carry;

  // ***************************
  // flag generator
  // ***************************
  psr_alu_flags #(
    .WIDTH (WIDTH)
  ) u_alu (
    .op               (alu_op),
    .file_operand     (file_operand),
    .w_operand        (w_operand),
    .logic_result     (logic_result),
    .result           (alu_result),
    .zero_out         (alu_zero),
    .nibble_carry_out (alu_nib),
    .carry_out        (alu_carry)
  );

  // ***************************
  // address decode
  // ***************************
  function is_flags_addr;
    input [8:0] a;
    begin
      is_flags_addr = ((a & `PSR_ADDR_MASK) == `PSR_ADDR_BANK0);
    end
  endfunction

  // mirrored in every bank
  assign dest_is_flags = is_flags_addr(dest_addr); // R1
  wire wr_hit = instr_en && dest_write && dest_is_flags; // R3

  // ***************************
  // write qualification
  // ***************************
  // a flag-setting instruction blocks the data write to all three alu bits
  wire [WIDTH-1:0] wd           = alu_result;
  wire             flag_touch   = flags_affect_z || flags_affect_c;
  wire             flag_data_wr = wr_hit && !flag_touch; // R4
  wire             z_update     = instr_en && flags_affect_z; // R4
  wire             c_update     = instr_en && flags_affect_c; // R4 R8
  wire             to_set_event = power_up_event || clrwdt_event || sleep_entry; // R5
  wire             pd_set_event = power_up_event || clrwdt_event; // R5

  // ***************************
  // next values: bank select
  // ***************************
  reg next_indirect_bank;
  reg next_direct_hi;
  reg next_direct_lo;

  // bank bits behave as plain file bits
  always @* begin
    next_indirect_bank = indirect_bank_reg;
    next_direct_hi     = direct_bank_select_hi;
    next_direct_lo     = direct_bank_select_lo;
    if (wr_hit) begin
      next_indirect_bank = wd[`PSR_BIT_IND_BANK_POS]; // R3 R6
      next_direct_hi     = wd[`PSR_BIT_RPH_POS]; // R6
      next_direct_lo     = wd[`PSR_BIT_RPL_POS]; // R6
    end
  end

  // ***************************
  // next values: zero flag
  // ***************************
  reg next_zero;

  // flag result overrides the data write
  always @* begin
    next_zero = zero_flag;
    if (flag_data_wr) begin
      next_zero = wd[`PSR_BIT_Z_POS]; // R3
    end
    if (z_update) begin
      next_zero = alu_zero; // R4 R6 R10
    end
  end

  // ***************************
  // next values: carries
  // ***************************
  reg next_nibble_carry;
  reg next_carry;

  always @* begin
    next_nibble_carry = nibble_carry_flag;
    next_carry        = carry_flag;
    if (flag_data_wr) begin
      next_nibble_carry = wd[`PSR_BIT_NIB_CARRY_POS]; // R3 R6
      next_carry        = wd[`PSR_BIT_C_POS]; // R3 R6
    end
    if (c_update) begin
      next_nibble_carry = alu_nib; // R4 R8
      next_carry        = alu_carry; // R4 R8
    end
  end

  // ***************************
  // next values: timeout
  // ***************************
  reg next_timeout;

  // expiry wins over the set events
  always @* begin
    next_timeout = watchdog_timeout_flag;
    if (to_set_event) begin
      next_timeout = 1'b1; // R5
    end
    if (watchdog_expired) begin
      next_timeout = 1'b0; // R5 R10
    end
  end

  // ***************************
  // next values: power down
  // ***************************
  reg next_power_down;

  // sleep wins over the set events
  always @* begin
    next_power_down = power_down_flag;
    if (pd_set_event) begin
      next_power_down = 1'b1; // R5
    end
    if (sleep_entry) begin
      next_power_down = 1'b0; // R5 R10
    end
  end

  // ***************************
  // register update
  // ***************************
  always @(posedge core_clk) begin
    if (reset) begin
      {indirect_bank_reg, direct_bank_select_hi, direct_bank_select_lo} <= `PSR_RESET_UPPER;
      watchdog_timeout_flag                      <= `PSR_RESET_TIMEOUT;
      power_down_flag                            <= `PSR_RESET_PWRDN;
      {zero_flag, nibble_carry_flag, carry_flag} <= `PSR_RESET_ALU;
    end else begin
      indirect_bank_reg     <= next_indirect_bank;
      direct_bank_select_hi <= next_direct_hi;
      direct_bank_select_lo <= next_direct_lo;
      watchdog_timeout_flag <= next_timeout;
      power_down_flag       <= next_power_down;
      zero_flag             <= next_zero;
      nibble_carry_flag     <= next_nibble_carry;
      carry_flag            <= next_carry;
    end
  end

  // ***************************
  // read image
  // ***************************
  always @(posedge core_clk) begin
    if (reset) begin
      flags_read_data <= {WIDTH{1'b0}};
    end else begin
      flags_read_data <= {indirect_bank_reg, direct_bank_select_hi, direct_bank_select_lo,
                          watchdog_timeout_flag, power_down_flag,
                          zero_flag, nibble_carry_flag, carry_flag}; // R2
    end
  end

  // ***************************
  // bank outputs
  // ***************************
  assign indirect_bank_select = indirect_bank_reg; // R9
  assign direct_bank          = {direct_bank_select_hi, direct_bank_select_lo}; // R9
endmodule

/* sim/psr_dp_model.sv */
// datapath model: spreads one command word onto the instruction inputs
// assumes the bench changes cmd just after a clock edge
`timescale 1ns/1ps
module psr_dp_model (
  input  wire [42:0] cmd,
  output wire        instr_en,
  output wire        dest_write,
  output wire        flags_affect_z,
  output wire        flags_affect_c,
  output wire        power_up_event,
  output wire        clrwdt_event,
  output wire        watchdog_expired,
  output wire        sleep_entry,
  output wire [1:0]  alu_op,
  output wire [8:0]  dest_addr,
  output wire [7:0]  file_operand,
  output wire [7:0]  w_operand,
  output wire [7:0]  logic_result
);
  assign {instr_en, dest_addr, alu_op, dest_write, flags_affect_z, flags_affect_c,
          file_operand, w_operand, logic_result, power_up_event, clrwdt_event,
          watchdog_expired, sleep_entry} = cmd;
endmodule

/* sim/psr_flags_sva.sv */
// checker: port assertions for the flags register
// assumes a bind onto psr_flags_reg
`timescale 1ns/1ps
module psr_flags_sva (
  input wire       core_clk,
  input wire       reset,
  input wire       instr_en,
  input wire       dest_write,
  input wire       flags_affect_z,
  input wire       flags_affect_c,
  input wire       watchdog_expired,
  input wire       sleep_entry,
  input wire       indirect_bank_select,
  input wire       dest_is_flags,
  input wire [1:0] alu_op,
  input wire [1:0] direct_bank,
  input wire [8:0] dest_addr,
  input wire [7:0] file_operand,
  input wire [7:0] w_operand,
  input wire [7:0] logic_result,
  input wire [7:0] flags_read_data,
  input wire [7:0] alu_result
);
  wire       wr = instr_en && dest_write && dest_is_flags;
  wire       zr = alu_result == 8'h00;
  wire [1:0] cy = {file_operand[3:0] >= w_operand[3:0], file_operand >= w_operand};
  wire [1:0] rc = flags_read_data[4:3];
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_addr_decode: assert property (dest_is_flags == (dest_addr[6:0] == 7'h03))
    else $error("bad decode");
  a_upper_write: assert property (wr && alu_op == 2'h2 |=>
    {indirect_bank_select, direct_bank} == $past(logic_result[7:5])) else $error("bad bank");
  a_zero_result: assert property (instr_en && flags_affect_z |->
    ##2 flags_read_data[2] == $past(zr, 2)) else $error("bad zero");
  a_bits_ro: assert property (!watchdog_expired && !sleep_entry |->
    ##2 (rc | $past(rc)) == rc) else $error("bad reset bits");
  a_clear_file: assert property (wr && alu_op == 2'h3 && flags_affect_z && !flags_affect_c |=>
    direct_bank == 2'h0 && !indirect_bank_select ##1
    flags_read_data[2] && flags_read_data[1:0] == $past(flags_read_data[1:0]))
    else $error("bad clear");
  a_sub_borrow: assert property (instr_en && flags_affect_c && alu_op == 2'h1 |->
    ##2 flags_read_data[1:0] == $past(cy, 2)) else $error("bad borrow");
  a_wdt_clear: assert property (watchdog_expired |-> ##2 !flags_read_data[4])
    else $error("bad timeout");
  a_sleep_flags: assert property (sleep_entry && !watchdog_expired |-> ##2 rc == 2'b10)
    else $error("bad sleep");
endmodule

/* sim/psr_flags_reg_tb_top.sv */
// bench: directed and random instructions checked against a bit model
// assumes a 4 ns clock and the command-word datapath model
`timescale 1ns/1ps
module psr_flags_reg_tb_top;
  logic        core_clk, reset;
  logic [42:0] cmd;
  logic [7:0]  m;
  wire         instr_en, dest_write, flags_affect_z, flags_affect_c, indirect_bank_select;
  wire         power_up_event, clrwdt_event, watchdog_expired, sleep_entry, dest_is_flags;
  wire  [1:0]  alu_op, direct_bank;
  wire  [8:0]  dest_addr;
  wire  [7:0]  file_operand, w_operand, logic_result, flags_read_data, alu_result;
  int          err_count, n_checks, r, i;
  psr_flags_reg i_psr_flags_reg (
    .core_clk             (core_clk),
    .reset                (reset),
    .instr_en             (instr_en),
    .dest_addr            (dest_addr),
    .dest_write           (dest_write),
    .alu_op               (alu_op),
    .flags_affect_z       (flags_affect_z),
    .flags_affect_c       (flags_affect_c),
    .file_operand         (file_operand),
    .w_operand            (w_operand),
    .logic_result         (logic_result),
    .power_up_event       (power_up_event),
    .clrwdt_event         (clrwdt_event),
    .watchdog_expired     (watchdog_expired),
    .sleep_entry          (sleep_entry),
    .flags_read_data      (flags_read_data),
    .alu_result           (alu_result),
    .indirect_bank_select (indirect_bank_select),
    .direct_bank          (direct_bank),
    .dest_is_flags        (dest_is_flags)
  );
  psr_dp_model i_psr_dp_model (
    .cmd              (cmd),
    .instr_en         (instr_en),
    .dest_write       (dest_write),
    .flags_affect_z   (flags_affect_z),
    .flags_affect_c   (flags_affect_c),
    .power_up_event   (power_up_event),
    .clrwdt_event     (clrwdt_event),
    .watchdog_expired (watchdog_expired),
    .sleep_entry      (sleep_entry),
    .alu_op           (alu_op),
    .dest_addr        (dest_addr),
    .file_operand     (file_operand),
    .w_operand        (w_operand),
    .logic_result     (logic_result)
  );
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic run(input [8:0] a, input [1:0] o, input [2:0] k, input [23:0] d,
                     input [3:0] e);
    k[0] = k[0] & !o[1];
    r = o == 0 ? d[23:16] + d[15:8] : o == 1 ? d[23:16] - d[15:8] + 256 : o == 2 ? d[7:0] : 0;
    if (k[2] && a[6:0] == 7'h03) m[7:5] = r[7:5];
    if (k == 3'h4 && a[6:0] == 7'h03) m[2:0] = r[2:0];
    if (k[1]) m[2] = r[7:0] == 0;
    if (k[0]) m[1:0] = {o[0] ? d[19:16] >= d[11:8] : d[19:16] + d[11:8] > 15, r > 255};
    if (e[3] | e[2]) m[4:3] = 2'b11;
    if (e[0]) m[4:3] = 2'b10;
    if (e[1]) m[4] = 1'b0;
    @(posedge core_clk) cmd <= {1'b1, a, o, k, d, e};
    #1 chk(alu_result, r[7:0]);
    chk({7'h0, dest_is_flags}, {7'h0, a[6:0] == 7'h03});
    @(posedge core_clk) cmd <= 43'h0;
    @(posedge core_clk) #1 chk(flags_read_data, m);
    chk({indirect_bank_select, direct_bank, 5'h0}, {m[7:5], 5'h0});
  endtask
  initial begin
    void'($urandom(32'hb9f8));
    reset = 1'b1;
    cmd = 43'h0;
    m = 8'h18;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(flags_read_data, m);
    run(9'h003, 2'h2, 3'h4, 24'h0000ff, 4'h0);
    run(9'h183, 2'h3, 3'h6, 24'h0, 4'h0);
    run(9'h103, 2'h1, 3'h7, 24'h102000, 4'h0);
    for (i = 0; i < 4; i++) run(9'h004, 2'h0, 3'h3, 24'h888800, 4'h1 << i);
    for (i = 0; i < 400; i++) run({2'($urandom), $urandom % 4 ? 7'h03 : 7'($urandom)},
      2'($urandom), 3'($urandom), 24'($urandom), $urandom % 6 ? 4'h0 : 4'h1 << $urandom % 4);
    end_of_test;
  end
endmodule
bind psr_flags_reg psr_flags_sva i_psr_flags_sva (
  .core_clk             (core_clk),
  .reset                (reset),
  .instr_en             (instr_en),
  .dest_write           (dest_write),
  .flags_affect_z       (flags_affect_z),
  .flags_affect_c       (flags_affect_c),
  .watchdog_expired     (watchdog_expired),
  .sleep_entry          (sleep_entry),
  .indirect_bank_select (indirect_bank_select),
  .dest_is_flags        (dest_is_flags),
  .alu_op               (alu_op),
  .direct_bank          (direct_bank),
  .dest_addr            (dest_addr),
  .file_operand         (file_operand),
  .w_operand            (w_operand),
  .logic_result         (logic_result),
  .flags_read_data      (flags_read_data),
  .alu_result           (alu_result)
);
